// File: host_timers_and_counters.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Run bit starts timer; clearing halts it
// - Run one-to-zero forces preload to FFFF
// - Preload in bits 15:0, reset FFFF
// - Timer raises host interrupts at intervals
// - Count register shows present timer value
// - Free counter from zero, per 25MHz tick
// - Free counter rolls over and continues
// - Half-word mode latches count on first read
// - Free counter may lag after reset
// - Free counter runs in every power state
// - Dropped-frame counter increments per drop
// - Reading drop counter clears it
// - Drop counter halfway crossing raises interrupt
module host_timers_and_counters
  import host_timers_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_dropped,
  output logic             irq
);
  import host_timers_pkg::*;

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  timer_cfg_t  cfg;
  logic [15:0] timer_current_count;
  logic [31:0] free_running_count;
  logic [31:0] dropped_frame_count;
  logic [31:0] free_latch;
  logic        half_mode;
  logic        half_pending;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] irq_event;
  logic [31:0] next_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  always_comb
  begin
    mapped = (paddr == TIMER_CONFIGURATION_OFF) || (paddr == TIMER_COUNT_OFF) ||
             (paddr == FREE_RUNNING_OFF) || (paddr == DROPPED_FRAME_OFF) ||
             (paddr == HALF_WORD_READ_OFF) || (paddr == IRQ_STATUS_OFF) ||
             (paddr == IRQ_MASK_OFF);
  end

  // Writes land at the access edge
  assign wr_en = psel && penable && pready && pwrite && mapped;
  // Read side effects at the setup edge, with the read data capture
  assign rd_en = psel && !penable && !pwrite && mapped;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // ----------------------------------------------------------------
  // Timer configuration
  // ----------------------------------------------------------------
  logic [31:0] cfg_word;
  logic [31:0] cfg_new;

  assign cfg_word = {2'b00, cfg.run, 13'h0000, cfg.preload};
  assign cfg_new  = merge(cfg_word, pwdata, pstrb);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg.run     <= 1'b0;
      cfg.preload <= PRELOAD_RESET;
    end
    else if (wr_en && paddr == TIMER_CONFIGURATION_OFF)
    begin
      cfg.run <= cfg_new[TIMER_RUN_BIT];
      if (cfg.run && !cfg_new[TIMER_RUN_BIT])
        cfg.preload <= PRELOAD_RESET;
      else
        cfg.preload <= cfg_new[15:0];
    end
  end

  // ----------------------------------------------------------------
  // 25 MHz tick
  // ----------------------------------------------------------------
  logic [15:0] phase;
  logic [15:0] next_phase;
  logic        tick;

  always_comb
  begin
    next_phase = phase + TICK_STEP;
    tick       = next_phase >= TICK_WRAP;
    if (tick)
      next_phase = next_phase - TICK_WRAP;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= 16'h0000;
    else
      phase <= next_phase;
  end

  // ----------------------------------------------------------------
  // General purpose timer
  // ----------------------------------------------------------------
  logic timer_wrap;

  assign timer_wrap = cfg.run && tick && (timer_current_count == 16'h0000);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_current_count <= COUNT_RESET;
    else if (!cfg.run && wr_en && paddr == TIMER_CONFIGURATION_OFF)
      timer_current_count <= cfg_new[15:0];
    else if (!cfg.run)
      timer_current_count <= cfg.preload;
    else if (timer_wrap)
      timer_current_count <= cfg.preload;
    else if (tick)
      timer_current_count <= timer_current_count - 16'h0001;
  end

  // ----------------------------------------------------------------
  // Free running counter
  // ----------------------------------------------------------------
  // No power-state gating; counts always
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      free_running_count <= 32'h0000_0000;
    else if (tick)
      free_running_count <= free_running_count + 32'h0000_0001;
  end

  // Half-word mode: low half read latches the whole count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_mode    <= 1'b0;
      half_pending <= 1'b0;
      free_latch   <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en && paddr == HALF_WORD_READ_OFF && pstrb[0])
        half_mode <= pwdata[0];
      if (rd_en && paddr == FREE_RUNNING_OFF && half_mode)
      begin
        if (!half_pending)
          free_latch <= free_running_count;
        half_pending <= !half_pending;
      end
    end
  end

  // ----------------------------------------------------------------
  // Dropped frame counter
  // ----------------------------------------------------------------
  logic drop_clear;
  logic drop_half;

  assign drop_clear = rd_en && paddr == DROPPED_FRAME_OFF;
  assign drop_half  = frame_dropped && !drop_clear && (dropped_frame_count == DROP_HALF_BEFORE);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dropped_frame_count <= 32'h0000_0000;
    else if (drop_clear)
      dropped_frame_count <= {31'h0000_0000, frame_dropped};
    else if (frame_dropped)
      dropped_frame_count <= dropped_frame_count + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_event[IRQ_TIMER_BIT]     = timer_wrap;
  assign irq_event[IRQ_DROP_HALF_BIT] = drop_half;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
    end
    else
    begin
      if (wr_en && paddr == IRQ_STATUS_OFF && pstrb[0])
        irq_status <= (irq_status & ~pwdata[IRQ_BITS-1:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      if (wr_en && paddr == IRQ_MASK_OFF && pstrb[0])
        irq_mask <= pwdata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      TIMER_CONFIGURATION_OFF: next_rdata = cfg_word;
      TIMER_COUNT_OFF:         next_rdata = {16'h0000, timer_current_count};
      FREE_RUNNING_OFF:        next_rdata = (half_mode && half_pending) ? free_latch
                                                                       : free_running_count;
      DROPPED_FRAME_OFF:       next_rdata = dropped_frame_count;
      HALF_WORD_READ_OFF:      next_rdata = {31'h0000_0000, half_mode};
      IRQ_STATUS_OFF:          next_rdata = {30'h0000_0000, irq_status};
      IRQ_MASK_OFF:            next_rdata = {30'h0000_0000, irq_mask};
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_run_fall;
    cfg.run ##1 !cfg.run;
  endsequence

  a_run_fall_preload: assert property (@(posedge clk) disable iff (!rst_n)
    s_run_fall |-> cfg.preload == PRELOAD_RESET)
    else $error("preload not forced on run fall");

  a_halted_count: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.run && !$past(cfg.run) |-> timer_current_count == cfg.preload)
    else $error("halted timer not holding preload");

  a_timer_decrement: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.run && tick && timer_current_count != 16'h0000 |=>
      timer_current_count == $past(timer_current_count) - 16'h0001)
    else $error("timer failed to decrement");

  a_timer_reload: assert property (@(posedge clk) disable iff (!rst_n)
    timer_wrap |=> timer_current_count == $past(cfg.preload) && irq_status[IRQ_TIMER_BIT])
    else $error("timer wrap missed reload or event");

  a_free_step: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> free_running_count == $past(free_running_count) + 32'h0000_0001)
    else $error("free counter missed tick");

  a_tick_rate: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && !tick |=> tick)
    else $error("tick rate wrong");

  a_drop_clear: assert property (@(posedge clk) disable iff (!rst_n)
    drop_clear && !frame_dropped |=> dropped_frame_count == 32'h0000_0000)
    else $error("drop counter not cleared on read");

  a_drop_count: assert property (@(posedge clk) disable iff (!rst_n)
    frame_dropped && !drop_clear |=>
      dropped_frame_count == $past(dropped_frame_count) + 32'h0000_0001)
    else $error("drop counter missed frame");

  a_drop_half_irq: assert property (@(posedge clk) disable iff (!rst_n)
    drop_half |=> irq_status[IRQ_DROP_HALF_BIT] ##1 (irq == irq_mask[IRQ_DROP_HALF_BIT]
                                                     || irq))
    else $error("halfway event lost");

  a_half_latch: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && paddr == FREE_RUNNING_OFF && half_mode && !half_pending |=>
      free_latch == $past(free_running_count) && half_pending)
    else $error("half-word latch failed");

  a_half_second: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && paddr == FREE_RUNNING_OFF && half_mode && half_pending |=>
      prdata == $past(free_latch) && !half_pending)
    else $error("second half-word read not from latch");

  a_run_start_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && paddr == TIMER_CONFIGURATION_OFF && !cfg.run |=>
      timer_current_count == $past(cfg_new[15:0]))
    else $error("timer not loaded from new preload");

  a_run_bit_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && paddr == TIMER_CONFIGURATION_OFF |=> cfg.run == $past(cfg_new[TIMER_RUN_BIT]))
    else $error("run bit not written");

  a_preload_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && paddr == TIMER_CONFIGURATION_OFF && !(cfg.run && !cfg_new[TIMER_RUN_BIT]) |=>
      cfg.preload == $past(cfg_new[15:0]))
    else $error("preload not written");

  a_free_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(free_running_count))
    else $error("free counter moved without tick");

  a_drop_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !frame_dropped && !drop_clear |=> $stable(dropped_frame_count))
    else $error("drop counter moved without drop");

  a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    |(irq_status & irq_mask) |=> irq)
    else $error("interrupt not raised");

  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !(|(irq_status & irq_mask)) |=> !irq)
    else $error("interrupt raised while nothing pending");

endmodule

// File: host_timers_and_counters_tb.sv
`timescale 1ns/100ps
module host_timers_and_counters_tb;
  import host_timers_pkg::*;

  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_dropped;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        err;
  int          fail_count;
  int          num_checks;
  int          cycles;

  host_timers_and_counters i_host_timers_and_counters (
    .clk           (clk),
    .rstn          (rstn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pstrb         (pstrb),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .frame_dropped (frame_dropped),
    .irq           (irq)
  );

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, 4'h0, q);
    chk(q, exp);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    frame_dropped = 1'b0;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values
    rdc(TIMER_CONFIGURATION_OFF, 32'h0000_ffff);
    rdc(TIMER_COUNT_OFF, 32'h0000_ffff);
    rdc(DROPPED_FRAME_OFF, 32'h0000_0000);
    rdc(IRQ_STATUS_OFF, 32'h0000_0000);
    // Unmapped address and read-only count
    apb(1'b0, 8'hc0, 32'h0000_0000, 4'h0, rd);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    wr(TIMER_COUNT_OFF, 32'h0000_1234);
    rdc(TIMER_COUNT_OFF, 32'h0000_ffff);
    // Timer run, decrement and wrap event
    wr(TIMER_CONFIGURATION_OFF, 32'h2000_0040);
    apb(1'b0, TIMER_COUNT_OFF, 32'h0000_0000, 4'h0, rd);
    chk({31'h0000_0000, (rd >= 32'h0000_003a && rd <= 32'h0000_0040)}, 32'h0000_0001);
    repeat (200) @(posedge clk);
    rdc(IRQ_STATUS_OFF, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(IRQ_MASK_OFF, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    // Halt clears run only; preload forced to all ones
    apb(1'b1, TIMER_CONFIGURATION_OFF, 32'h0000_0000, 4'b1000, rd);
    rdc(TIMER_CONFIGURATION_OFF, 32'h0000_ffff);
    rdc(TIMER_COUNT_OFF, 32'h0000_ffff);
    wr(IRQ_STATUS_OFF, 32'h0000_0001);
    rdc(IRQ_STATUS_OFF, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    // Free counter rate: 80 clocks give 50 ticks
    apb(1'b0, FREE_RUNNING_OFF, 32'h0000_0000, 4'h0, rd);
    repeat (77) @(posedge clk);
    apb(1'b0, FREE_RUNNING_OFF, 32'h0000_0000, 4'h0, rd2);
    chk(rd2 - rd, 32'h0000_0032);
    // Half-word mode latches on first read
    wr(HALF_WORD_READ_OFF, 32'h0000_0001);
    apb(1'b0, FREE_RUNNING_OFF, 32'h0000_0000, 4'h0, rd);
    repeat (5) @(posedge clk);
    apb(1'b0, FREE_RUNNING_OFF, 32'h0000_0000, 4'h0, rd2);
    chk(rd2, rd);
    wr(HALF_WORD_READ_OFF, 32'h0000_0000);
    // Dropped frames count and clear on read
    @(posedge clk);
    frame_dropped <= 1'b1;
    repeat (3) @(posedge clk);
    frame_dropped <= 1'b0;
    rdc(DROPPED_FRAME_OFF, 32'h0000_0003);
    rdc(DROPPED_FRAME_OFF, 32'h0000_0000);
    test_done();
  end
endmodule

// File: host_timers_pkg.sv
package host_timers_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_CONFIGURATION_OFF = 8'h8c;
  localparam logic [7:0] TIMER_COUNT_OFF         = 8'h90;
  localparam logic [7:0] FREE_RUNNING_OFF        = 8'h9c;
  localparam logic [7:0] DROPPED_FRAME_OFF       = 8'ha0;
  localparam logic [7:0] HALF_WORD_READ_OFF      = 8'hb0;
  localparam logic [7:0] IRQ_STATUS_OFF          = 8'hb4;
  localparam logic [7:0] IRQ_MASK_OFF            = 8'hb8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          TIMER_RUN_BIT       = 29;
  localparam logic [15:0] PRELOAD_RESET       = 16'hffff;
  localparam logic [15:0] COUNT_RESET         = 16'hffff;
  localparam logic [31:0] DROP_HALF_BEFORE    = 32'h7fff_ffff;
  localparam int          IRQ_TIMER_BIT       = 0;
  localparam int          IRQ_DROP_HALF_BIT   = 1;
  localparam int          IRQ_BITS            = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 40_000_000;
  localparam int TICK_HZ          = 25_000_000;
  localparam int FREE_CLEAR_NS    = 160;
  localparam int FREE_CLEAR_CYCLES =
    (FREE_CLEAR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Phase accumulator step for a 25 MHz tick out of 40 MHz
  localparam logic [15:0] TICK_STEP = 16'(TICK_HZ / 1000);
  localparam logic [15:0] TICK_WRAP = 16'(CLK_HZ / 1000);

  typedef struct packed {
    logic        run;
    logic [15:0] preload;
  } timer_cfg_t;

endpackage
